// ---- chirq_pkg.sv ----
// Shared constants of the channel interrupt flag and enable block
package chirq_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 8;
	localparam int IDX_W = 8;
	localparam int ADDR_LSB = 2;
	localparam int FAULT_W = 8;
	localparam int LINE_W = 4;
	localparam int SERIAL_W = 3;

	// ****************************************
	// Register indices, byte address is index times four
	// ****************************************
	localparam logic [IDX_W-1:0] IDX_SERIAL_DATA = 8'h90;
	localparam logic [IDX_W-1:0] IDX_FAULT_FLAGS = 8'h93;
	localparam logic [IDX_W-1:0] IDX_FAULT_EN = 8'h94;
	localparam logic [IDX_W-1:0] IDX_LINE_FLAGS = 8'h95;
	localparam logic [IDX_W-1:0] IDX_LINE_EN = 8'h96;
	localparam logic [IDX_W-1:0] IDX_SERIAL_FLAGS = 8'h97;
	localparam logic [IDX_W-1:0] IDX_SERIAL_EN = 8'h98;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int LINE_RISE_BIT = 0;
	localparam int LINE_FALL_BIT = 1;
	localparam int RP_SEEN_BIT = 2;
	localparam int RP_ERR_BIT = 3;
	localparam int TX_FREE_BIT = 0;
	localparam int RX_BYTE_BIT = 1;
	localparam int RX_OVR_BIT = 2;
	localparam int FLT_LINE_SHUT_BIT = 3;

	// ****************************************
	// Reset values and bus codes
	// ****************************************
	localparam logic [DATA_W-1:0] ENABLE_RST = 8'h00;
	localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : chirq_pkg

// ---- chirq_reg_if.sv ----
// Internal register access strobes between bus slave and register bank
`timescale 1ns/1ps
interface chirq_reg_if;
	logic wr_en;
	logic rd_en;
	logic [chirq_pkg::IDX_W-1:0] idx;
	logic [chirq_pkg::DATA_W-1:0] wdata;
	logic [chirq_pkg::DATA_W-1:0] rdata;
	modport slave (output wr_en, rd_en, idx, wdata, input rdata);
	modport regs (input wr_en, rd_en, idx, wdata, output rdata);
endinterface : chirq_reg_if

// ---- chirq_flag_bank.sv ----
// Sticky event flags cleared by a read, set wins over clear
`timescale 1ns/1ps
module chirq_flag_bank #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Events and clear
	input wire logic [WIDTH-1:0] set_i,
	input wire logic clr_i,
	// Flags
	output logic [WIDTH-1:0] flags_o
);
	if (WIDTH < 1 || WIDTH > chirq_pkg::DATA_W) begin : g_chk
		$error("chirq_flag_bank: WIDTH out of range");
	end

	// ****************************************
	// One sticky bit per event
	// ****************************************
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		// Event in the clearing cycle survives so no event is lost
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				flags_o[i] <= chirq_pkg::FLAGS_RST[i];
			end else begin
				flags_o[i] <= set_i[i] | (flags_o[i] & ~clr_i);
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
		else $error("event lost");
	chk_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(clr_i && set_i == '0) |=> (flags_o == '0))
		else $error("read did not clear flags");
	chk_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!clr_i) |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
		else $error("flag dropped without read");
endmodule : chirq_flag_bank

// ---- chirq_ahb_slave.sv ----
// AHB-Lite slave with one wait state turning transfers into strobes
`timescale 1ns/1ps
module chirq_ahb_slave (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Register strobes
	chirq_reg_if.slave reg_bus
);
	typedef enum logic {ST_ADDR, ST_DATA} chirq_state_type;

	chirq_state_type state_ff;
	logic [31:0] addr_ff;
	logic write_ff;
	logic size_ok_ff;
	logic hit;
	logic take;

	// ****************************************
	// Address phase capture
	// ****************************************
	assign take = hsel_i && hready_i && htrans_i[1] && state_ff == ST_ADDR;

	// Latch the address phase, stall data phase one cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_ADDR;
			addr_ff <= 32'h0000_0000;
			write_ff <= 1'b0;
			size_ok_ff <= 1'b0;
		end else if (take) begin
			state_ff <= ST_DATA;
			addr_ff <= haddr_i;
			write_ff <= hwrite_i;
			size_ok_ff <= (hsize_i == chirq_pkg::HSIZE_WORD);
		end else begin
			state_ff <= ST_ADDR;
		end
	end

	// ****************************************
	// Data phase strobes
	// ****************************************
	// Out of range or sub-word access is ignored, reads zero
	assign hit = state_ff == ST_DATA && size_ok_ff && addr_ff[31:10] == 22'h00_0000
		&& addr_ff[chirq_pkg::ADDR_LSB-1:0] == 2'h0;
	assign reg_bus.idx = addr_ff[chirq_pkg::ADDR_LSB +: chirq_pkg::IDX_W];
	assign reg_bus.wdata = hwdata_i[chirq_pkg::DATA_W-1:0];
	assign reg_bus.wr_en = hit && write_ff;
	assign reg_bus.rd_en = hit && !write_ff;

	// Wait state keeps hrdata registered at the cost of a cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hreadyout_o <= 1'b1;
			hrdata_o <= 32'h0000_0000;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= !take;
			hresp_o <= 1'b0;
			if (reg_bus.rd_en) begin
				hrdata_o <= {{(32-chirq_pkg::DATA_W){1'b0}}, reg_bus.rdata};
			end else if (state_ff == ST_DATA) begin
				hrdata_o <= 32'h0000_0000;
			end
		end
	end

	chk_one_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		take |=> !hreadyout_o ##1 hreadyout_o)
		else $error("wait state length wrong");
endmodule : chirq_ahb_slave

// ---- chirq_top.sv ----
// Channel interrupt flags, enables and serial data byte, on AHB-Lite
//
// Summary of operation
// - Fault enable register, eight read/write bits
// - Enable bit one enables; enables reset zero
// - Line event bits seven to four reserved zero
// - Ready pulse error sets bit three
// - Valid ready pulse sets bit two
// - Line falling edge sets bit one
// - Line rising edge sets bit zero
// - Line event enables in bits three to zero
// - Serial flags: overrun bit two, bits seven to three reserved
// - Received byte sets bit one, byte readable
// - Transmitter free sets bit zero
// - Serial enables in bits two to zero
// - Fault flags match enables, read clear
// - Overrun means unread byte was overwritten
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module chirq_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Fault and channel events
	input wire logic [chirq_pkg::FAULT_W-1:0] fault_evt_i,
	input wire logic channel_powered_i,
	input wire logic comm_line_i,
	input wire logic rp_error_i,
	input wire logic rp_valid_i,
	// Serial port
	input wire logic rx_valid_i,
	input wire logic [chirq_pkg::DATA_W-1:0] rx_data_i,
	input wire logic tx_free_i,
	output logic [chirq_pkg::DATA_W-1:0] tx_data_o,
	output logic tx_load_o,
	// Interrupt request
	output logic irq_o
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_ff;
	logic rst_n;

	// Assert at once, release two edges later
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	// ****************************************
	// Bus slave
	// ****************************************
	chirq_reg_if bus ();

	chirq_ahb_slave u_slave (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.reg_bus(bus.slave)
	);

	// ****************************************
	// Enable registers
	// ****************************************
	logic [chirq_pkg::FAULT_W-1:0] fault_en_ff;
	logic [chirq_pkg::LINE_W-1:0] line_en_ff;
	logic [chirq_pkg::SERIAL_W-1:0] serial_en_ff;

	// Reserved enable bits are not stored, so they read zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fault_en_ff <= chirq_pkg::ENABLE_RST[chirq_pkg::FAULT_W-1:0];
			line_en_ff <= chirq_pkg::ENABLE_RST[chirq_pkg::LINE_W-1:0];
			serial_en_ff <= chirq_pkg::ENABLE_RST[chirq_pkg::SERIAL_W-1:0];
		end else if (bus.wr_en) begin
			case (bus.idx)
				chirq_pkg::IDX_FAULT_EN: begin
					fault_en_ff <= bus.wdata[chirq_pkg::FAULT_W-1:0];
				end
				chirq_pkg::IDX_LINE_EN: begin
					line_en_ff <= bus.wdata[chirq_pkg::LINE_W-1:0];
				end
				chirq_pkg::IDX_SERIAL_EN: begin
					serial_en_ff <= bus.wdata[chirq_pkg::SERIAL_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Line edge detection
	// ****************************************
	logic line_prev_ff;
	logic line_arm_ff;
	logic line_rise;
	logic line_fall;

	// First sample after reset only arms, avoiding a false edge
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			line_prev_ff <= 1'b0;
			line_arm_ff <= 1'b0;
		end else begin
			line_prev_ff <= comm_line_i;
			line_arm_ff <= 1'b1;
		end
	end

	assign line_rise = line_arm_ff && !line_prev_ff && comm_line_i;
	assign line_fall = line_arm_ff && line_prev_ff && !comm_line_i;

	// ****************************************
	// Serial data byte
	// ****************************************
	logic [chirq_pkg::DATA_W-1:0] rx_data_ff;
	logic rx_unread_ff;
	logic data_rd;
	logic data_wr;
	logic rx_overrun;

	assign data_rd = bus.rd_en && bus.idx == chirq_pkg::IDX_SERIAL_DATA;
	assign data_wr = bus.wr_en && bus.idx == chirq_pkg::IDX_SERIAL_DATA;
	// A byte read in the arrival cycle is the old one, no overrun
	assign rx_overrun = rx_valid_i && rx_unread_ff && !data_rd;

	// Newest byte always kept; unread mark set wins over read
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_ff <= chirq_pkg::DATA_RST;
			rx_unread_ff <= 1'b0;
		end else begin
			if (rx_valid_i) begin
				rx_data_ff <= rx_data_i;
			end
			rx_unread_ff <= rx_valid_i | (rx_unread_ff & ~data_rd);
		end
	end

	// Transmit byte handed out with a one-cycle load pulse
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_data_o <= chirq_pkg::DATA_RST;
			tx_load_o <= 1'b0;
		end else begin
			tx_load_o <= data_wr;
			if (data_wr) begin
				tx_data_o <= bus.wdata;
			end
		end
	end

	// ****************************************
	// Source flags
	// ****************************************
	logic [chirq_pkg::FAULT_W-1:0] fault_flags;
	logic [chirq_pkg::FAULT_W-1:0] fault_set;
	logic [chirq_pkg::LINE_W-1:0] line_flags;
	logic [chirq_pkg::LINE_W-1:0] line_set;
	logic [chirq_pkg::SERIAL_W-1:0] serial_flags;
	logic [chirq_pkg::SERIAL_W-1:0] serial_set;

	// Line shutdown event only meaningful on a powered channel
	always_comb begin
		fault_set = fault_evt_i;
		fault_set[chirq_pkg::FLT_LINE_SHUT_BIT] =
			fault_evt_i[chirq_pkg::FLT_LINE_SHUT_BIT] && channel_powered_i;
		line_set = '0;
		line_set[chirq_pkg::RP_ERR_BIT] = rp_error_i;
		line_set[chirq_pkg::RP_SEEN_BIT] = rp_valid_i;
		line_set[chirq_pkg::LINE_FALL_BIT] = line_fall;
		line_set[chirq_pkg::LINE_RISE_BIT] = line_rise;
		serial_set = '0;
		serial_set[chirq_pkg::RX_OVR_BIT] = rx_overrun;
		serial_set[chirq_pkg::RX_BYTE_BIT] = rx_valid_i;
		serial_set[chirq_pkg::TX_FREE_BIT] = tx_free_i;
	end

	chirq_flag_bank #(.WIDTH(chirq_pkg::FAULT_W)) u_fault_flags (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.set_i(fault_set),
		.clr_i(bus.rd_en && bus.idx == chirq_pkg::IDX_FAULT_FLAGS),
		.flags_o(fault_flags)
	);

	chirq_flag_bank #(.WIDTH(chirq_pkg::LINE_W)) u_line_flags (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.set_i(line_set),
		.clr_i(bus.rd_en && bus.idx == chirq_pkg::IDX_LINE_FLAGS),
		.flags_o(line_flags)
	);

	chirq_flag_bank #(.WIDTH(chirq_pkg::SERIAL_W)) u_serial_flags (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.set_i(serial_set),
		.clr_i(bus.rd_en && bus.idx == chirq_pkg::IDX_SERIAL_FLAGS),
		.flags_o(serial_flags)
	);

	// ****************************************
	// Read data
	// ****************************************
	// Narrow registers zero-filled; unmapped index reads zero
	always_comb begin
		case (bus.idx)
			chirq_pkg::IDX_SERIAL_DATA: bus.rdata = rx_data_ff;
			chirq_pkg::IDX_FAULT_FLAGS: bus.rdata = fault_flags;
			chirq_pkg::IDX_FAULT_EN: bus.rdata = fault_en_ff;
			chirq_pkg::IDX_LINE_FLAGS: begin
				bus.rdata = {{(chirq_pkg::DATA_W-chirq_pkg::LINE_W){1'b0}}, line_flags};
			end
			chirq_pkg::IDX_LINE_EN: begin
				bus.rdata = {{(chirq_pkg::DATA_W-chirq_pkg::LINE_W){1'b0}}, line_en_ff};
			end
			chirq_pkg::IDX_SERIAL_FLAGS: begin
				bus.rdata = {{(chirq_pkg::DATA_W-chirq_pkg::SERIAL_W){1'b0}}, serial_flags};
			end
			chirq_pkg::IDX_SERIAL_EN: begin
				bus.rdata = {{(chirq_pkg::DATA_W-chirq_pkg::SERIAL_W){1'b0}}, serial_en_ff};
			end
			default: bus.rdata = chirq_pkg::DATA_RST;
		endcase
	end

	// ****************************************
	// Interrupt request
	// ****************************************
	logic any_pend;

	assign any_pend = |(fault_flags & fault_en_ff) | |(line_flags & line_en_ff)
		| |(serial_flags & serial_en_ff);

	// Registered so the pin never glitches
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= any_pend;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_fault_en_write: assert property (
		bus.wr_en && bus.idx == chirq_pkg::IDX_FAULT_EN |=> fault_en_ff == $past(bus.wdata))
		else $error("fault enable not written");
	chk_enables_mask: assert property (
		fault_en_ff == '0 && line_en_ff == '0 && serial_en_ff == '0 |=> !irq_o)
		else $error("interrupt with all enables off");
	chk_line_reserved: assert property (
		bus.idx == chirq_pkg::IDX_LINE_FLAGS || bus.idx == chirq_pkg::IDX_LINE_EN
		|-> bus.rdata[7:4] == 4'h0)
		else $error("line reserved bits nonzero");
	chk_rp_error_set: assert property (
		rp_error_i |=> line_flags[chirq_pkg::RP_ERR_BIT])
		else $error("ready pulse error flag not set");
	chk_rp_seen_set: assert property (
		rp_valid_i |=> line_flags[chirq_pkg::RP_SEEN_BIT])
		else $error("ready pulse seen flag not set");
	chk_line_fall: assert property (
		$fell(comm_line_i) && line_arm_ff |=> line_flags[chirq_pkg::LINE_FALL_BIT])
		else $error("falling edge flag not set");
	chk_line_rise: assert property (
		$rose(comm_line_i) && line_arm_ff |=> line_flags[chirq_pkg::LINE_RISE_BIT])
		else $error("rising edge flag not set");
	chk_line_en_write: assert property (
		bus.wr_en && bus.idx == chirq_pkg::IDX_LINE_EN |=> line_en_ff == $past(bus.wdata[3:0]))
		else $error("line enable not written");
	chk_serial_reserved: assert property (
		bus.idx == chirq_pkg::IDX_SERIAL_FLAGS || bus.idx == chirq_pkg::IDX_SERIAL_EN
		|-> bus.rdata[7:3] == 5'h00)
		else $error("serial reserved bits nonzero");
	chk_rx_byte: assert property (
		rx_valid_i |=> rx_data_ff == $past(rx_data_i) && serial_flags[chirq_pkg::RX_BYTE_BIT])
		else $error("received byte not captured");
	chk_tx_free: assert property (
		tx_free_i |=> serial_flags[chirq_pkg::TX_FREE_BIT])
		else $error("transmit free flag not set");
	chk_fault_flag: assert property (
		fault_evt_i[7] |=> fault_flags[7])
		else $error("fault flag not set");
	chk_overrun: assert property (
		rx_valid_i ##1 (!data_rd [*2] ##0 rx_valid_i) |=> serial_flags[chirq_pkg::RX_OVR_BIT])
		else $error("overrun not flagged");
	chk_irq_follow: assert property (
		1'b1 |=> irq_o == $past(any_pend))
		else $error("interrupt not following pending");

	cov_line_read: cover property (line_flags != '0 ##1 bus.rd_en
		&& bus.idx == chirq_pkg::IDX_LINE_FLAGS);
	cov_overrun: cover property (rx_overrun);
	cov_irq_rise: cover property ($rose(irq_o));
	cov_set_on_clear: cover property (rp_valid_i && bus.rd_en
		&& bus.idx == chirq_pkg::IDX_LINE_FLAGS);
endmodule : chirq_top

// ---- chirq_host_model.sv ----
// Host side bus master model that reaches the interrupt flag and enable registers
`timescale 1ns/1ps
module chirq_host_model (
	// Clock
	input wire logic clk_i,
	// Bus answer
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	// Channel state known to the host
	input wire logic channel_powered_i,
	// Bus request
	output logic hsel_o,
	output logic [31:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [2:0] hsize_o,
	output logic [31:0] hwdata_o
);
	// ****************************************
	// Idle bus from time zero
	// ****************************************
	initial begin
		hsel_o = 1'b0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = chirq_pkg::HSIZE_WORD;
		hwdata_o = 32'h0;
	end

	// One single word transfer; the bus is sampled before the edge's own updates land
	task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd, output logic ok);
		int n;
		@(posedge clk_i);
		hsel_o <= 1'b1;
		haddr_o <= addr;
		htrans_o <= 2'h2;
		hwrite_o <= wr;
		hsize_o <= chirq_pkg::HSIZE_WORD;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 20);
		hsel_o <= 1'b0;
		htrans_o <= 2'h0;
		hwdata_o <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 40);
		ok = (hready_i === 1'b1);
		rd = hrdata_i;
	endtask : xfer

	// Edge flags mean nothing on an unpowered channel, so the host drops them
	function automatic logic [7:0] usable_line_flags(input logic [7:0] raw);
		return channel_powered_i ? raw : (raw & 8'hfc);
	endfunction : usable_line_flags
endmodule : chirq_host_model

// ---- chirq_top_tb.sv ----
// Self-checking testbench of the channel interrupt flag and enable block
`timescale 1ns/1ps
module chirq_top_tb;
	// ****************************************
	// Byte addresses and register tables
	// ****************************************
	localparam logic [31:0] A_DATA = {22'h0, chirq_pkg::IDX_SERIAL_DATA, 2'h0};
	localparam logic [31:0] FL_A [3] = '{{22'h0, chirq_pkg::IDX_FAULT_FLAGS, 2'h0},
		{22'h0, chirq_pkg::IDX_LINE_FLAGS, 2'h0}, {22'h0, chirq_pkg::IDX_SERIAL_FLAGS, 2'h0}};
	localparam logic [31:0] EN_A [3] = '{{22'h0, chirq_pkg::IDX_FAULT_EN, 2'h0},
		{22'h0, chirq_pkg::IDX_LINE_EN, 2'h0}, {22'h0, chirq_pkg::IDX_SERIAL_EN, 2'h0}};
	localparam logic [7:0] MSK [3] = '{8'hff, 8'h0f, 8'h07};
	localparam int WID [3] = '{8, 4, 3};

	logic clk_i, rst_n_i, hsel, hwrite, hready, hresp, powered, comm_line;
	logic rp_error, rp_valid, rx_valid, tx_free, tx_load, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] fault_evt, rx_data, tx_data;
	logic [31:0] rd;
	int mismatches, check_count, loads, g, b, p;

	// ****************************************
	// Design, host model and clock
	// ****************************************
	chirq_top u_chirq_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.fault_evt_i(fault_evt), .channel_powered_i(powered), .comm_line_i(comm_line),
		.rp_error_i(rp_error), .rp_valid_i(rp_valid), .rx_valid_i(rx_valid),
		.rx_data_i(rx_data), .tx_free_i(tx_free), .tx_data_o(tx_data), .tx_load_o(tx_load),
		.irq_o(irq));
	chirq_host_model u_chirq_host_model (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata),
		.channel_powered_i(powered), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
		.hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Count transmit loads, the pulse is too short to poll from a task
	always @(posedge clk_i) begin
		if (tx_load === 1'b1) loads <= loads + 1;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out;
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic acc(input logic [31:0] a, input logic wr, input logic [7:0] wd);
		logic ok;
		u_chirq_host_model.xfer(a, wr, {24'h0, wd}, rd, ok);
		cmp({31'h0, hresp}, 32'h0, "response not okay");
		if (!ok) begin
			mismatches++;
			$display("BAD %0t bus transfer hung", $time);
			close_out();
		end
	endtask : acc

	task automatic rchk(input logic [31:0] a, input logic [7:0] exp, input string what);
		acc(a, 1'b0, 8'h00);
		cmp(rd, {24'h0, exp}, what);
	endtask : rchk

	// Events s: ready pulse error, ready pulse seen, byte received, transmitter free
	task automatic pulse(input logic [7:0] f, input logic [3:0] s, input logic [7:0] d);
		@(posedge clk_i);
		fault_evt <= f;
		{rp_error, rp_valid, rx_valid, tx_free} <= s;
		rx_data <= d;
		@(posedge clk_i);
		fault_evt <= 8'h00;
		{rp_error, rp_valid, rx_valid, tx_free} <= 4'h0;
	endtask : pulse

	// Source b of group g; the line edges move the level and let it settle
	task automatic fire(input int gi, input int bi);
		if (gi == 0) pulse(8'h1 << bi, 4'h0, 8'h00);
		else if (gi == 1 && bi < 2) begin
			@(posedge clk_i);
			comm_line <= (bi == 0);
			repeat (2) @(posedge clk_i);
		end
		else if (gi == 1) pulse(8'h00, (bi == 2) ? 4'h4 : 4'h8, 8'h00);
		else if (bi == 0) pulse(8'h00, 4'h1, 8'h00);
		else begin
			pulse(8'h00, 4'h2, 8'h11);
			if (bi == 2) pulse(8'h00, 4'h2, 8'hc3);
		end
	endtask : fire

	// Raised within four cycles, or held low over four cycles
	task automatic irq_expect(input logic exp);
		for (int n = 0; n < 4; n++) begin
			@(negedge clk_i);
			if (exp && irq === 1'b1) break;
			if (!exp) cmp({31'h0, irq}, 32'h0, "irq while nothing enabled is pending");
		end
		if (exp) cmp({31'h0, irq}, 32'h1, "irq missing");
	endtask : irq_expect

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n_i = 1'b0;
		{powered, comm_line, rp_error, rp_valid, rx_valid, tx_free} = 6'h20;
		fault_evt = 8'h00;
		rx_data = 8'h00;
		mismatches = 0;
		check_count = 0;
		loads = 0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		// Every flag and enable register reads zero after reset
		for (g = 0; g < 3; g++) begin
			rchk(FL_A[g], 8'h00, "flags reset");
			rchk(EN_A[g], 8'h00, "enable reset");
		end
		// Enables keep written bits, reserved bits stay zero
		for (p = 0; p < 2; p++) begin
			for (g = 0; g < 3; g++) begin
				acc(EN_A[g], 1'b1, p ? 8'ha5 : 8'hff);
				rchk(EN_A[g], MSK[g] & (p ? 8'ha5 : 8'hff), "enable readback");
			end
		end
		acc(EN_A[2] + 32'h4, 1'b1, 8'hff);
		rchk(EN_A[2] + 32'h4, 8'h00, "unmapped read");
		// Each source: masked, then enabled, then cleared by the read
		for (g = 0; g < 3; g++) begin
			for (b = 0; b < WID[g]; b++) begin
				p = (g == 2 && b == 2) ? 6 : (1 << b);
				acc(EN_A[g], 1'b1, ~p[7:0]);
				fire(g, b);
				irq_expect(1'b0);
				acc(EN_A[g], 1'b1, p[7:0]);
				irq_expect(1'b1);
				rchk(FL_A[g], p[7:0], "source flag");
				irq_expect(1'b0);
			end
		end
		// Last byte readable; after reading it a new byte is no overrun
		rchk(A_DATA, 8'hc3, "received byte");
		pulse(8'h00, 4'h2, 8'h69);
		rchk(FL_A[2], 8'h02, "byte without overrun");
		rchk(A_DATA, 8'h69, "second byte");
		// Event drops just after the clearing edge, so only set-wins keeps the flag
		@(posedge clk_i);
		fault_evt <= 8'h01;
		fork
			rchk(FL_A[0], 8'h01, "flag under event");
			begin
				repeat (3) @(posedge clk_i);
				fault_evt <= 8'h00;
			end
		join
		rchk(FL_A[0], 8'h01, "event beat the clear");
		rchk(FL_A[0], 8'h00, "flag cleared");
		// Unpowered channel: line shutdown ignored, host drops edge flags
		@(posedge clk_i);
		powered <= 1'b0;
		pulse(8'h08, 4'h0, 8'h00);
		rchk(FL_A[0], 8'h00, "shutdown flag while unpowered");
		fire(1, 0);
		acc(FL_A[1], 1'b0, 8'h00);
		cmp(rd, 32'h1, "edge flag raw while unpowered");
		cmp({24'h0, u_chirq_host_model.usable_line_flags(rd[7:0])}, 32'h0, "edge used");
		powered <= 1'b1;
		// Byte for the transmitter
		acc(A_DATA, 1'b1, 8'h5a);
		repeat (2) @(negedge clk_i);
		cmp({24'h0, tx_data}, 32'h5a, "transmit byte");
		cmp(loads, 32'h1, "transmit load count");
		close_out();
	end
endmodule : chirq_top_tb
